/* pcr_pkg.sv */
// package for the pwm count register set: map, fields, reset values, carriers
// assumes a 32-bit apb slave with one byte register per aligned word
package pcr_pkg;

  localparam int PCR_CHANNELS = 3;          // number of pwm channels
  localparam int PCR_ADDR_W = 12;           // apb address width used

  // per-channel register index inside a channel block
  localparam logic [3:0] PCR_IDX_PH_LO = 4'h0;     // start delay count low
  localparam logic [3:0] PCR_IDX_PH_HI = 4'h1;     // start delay count high
  localparam logic [3:0] PCR_IDX_DC_LO = 4'h2;     // duty count low
  localparam logic [3:0] PCR_IDX_DC_HI = 4'h3;     // duty count high
  localparam logic [3:0] PCR_IDX_PR_LO = 4'h4;     // period count low
  localparam logic [3:0] PCR_IDX_PR_HI = 4'h5;     // period count high
  localparam logic [3:0] PCR_IDX_OF_LO = 4'h6;     // shift count low
  localparam logic [3:0] PCR_IDX_OF_HI = 4'h7;     // shift count high
  localparam logic [3:0] PCR_IDX_TM_LO = 4'h8;     // timer value low
  localparam logic [3:0] PCR_IDX_TM_HI = 4'h9;     // timer value high
  localparam logic [3:0] PCR_IDX_CTRL = 4'hA;      // channel control

  // byte address layout: channel block at 0x040 * (ch + 1), word index in [5:2]
  localparam logic [1:0] PCR_BLK_CH1 = 2'h1;       // block of channel 0
  localparam logic [11:0] PCR_ADDR_EN_MIR = 12'h000;  // enable mirror
  localparam logic [11:0] PCR_ADDR_LD_MIR = 12'h004;  // reload arm mirror
  localparam logic [11:0] PCR_ADDR_OUT_MIR = 12'h008; // output state mirror

  // channel control byte fields
  localparam int PCR_CTRL_ON_BIT = 7;       // module on
  localparam int PCR_CTRL_OUT_BIT = 5;      // output state
  localparam int PCR_CTRL_ARM_BIT = 4;      // reload arm
  localparam int PCR_MIR_W = 3;             // implemented mirror bits

  localparam logic [7:0] PCR_CTRL_RST = 8'h00;  // control reset value
  localparam logic [2:0] PCR_MIR_RST = 3'h0;    // mirror bits reset value

  // one channel's count storage, not reset (keeps contents through resets)
  typedef struct packed {
    logic [15:0] start_delay_count;  // phase
    logic [15:0] duty_count;         // duty cycle
    logic [15:0] period_count;       // period
    logic [15:0] shift_count;        // offset
    logic [15:0] timer_value;        // timer
  } pcr_counts_s;

  // apb request as seen by the slave
  typedef struct packed {
    logic sel;                       // psel
    logic enable;                    // penable
    logic write;                     // pwrite
    logic [PCR_ADDR_W-1:0] addr;     // byte address
    logic [31:0] wdata;              // write data
  } pcr_apb_req_s;

endpackage : pcr_pkg

/* pcr_channel_counts.sv */
// one channel's five 16-bit count registers, byte writable
// assumes single-cycle write strobes from the apb decoder in the same clock
`timescale 1ns/10ps
module pcr_channel_counts
  import pcr_pkg::*;
(
  input wire logic pclk,                 // bus clock
  input wire logic wr_en,                // write strobe, this channel
  input wire logic [3:0] idx,            // register index
  input wire logic [7:0] wbyte,          // write byte
  output pcr_counts_s counts             // stored counts
);

  // state of the counts, a single packed struct
  pcr_counts_s st;
  pcr_counts_s next_st;

  // byte lane update; no reset on purpose so contents survive soft resets
  always_comb begin
    next_st = st;
    if (wr_en) begin
      case (idx)
        PCR_IDX_PH_LO: next_st.start_delay_count[7:0] = wbyte;
        PCR_IDX_PH_HI: next_st.start_delay_count[15:8] = wbyte;
        PCR_IDX_DC_LO: next_st.duty_count[7:0] = wbyte;
        PCR_IDX_DC_HI: next_st.duty_count[15:8] = wbyte;
        PCR_IDX_PR_LO: next_st.period_count[7:0] = wbyte;
        PCR_IDX_PR_HI: next_st.period_count[15:8] = wbyte;
        PCR_IDX_OF_LO: next_st.shift_count[7:0] = wbyte;
        PCR_IDX_OF_HI: next_st.shift_count[15:8] = wbyte;
        PCR_IDX_TM_LO: next_st.timer_value[7:0] = wbyte;
        PCR_IDX_TM_HI: next_st.timer_value[15:8] = wbyte;
        default: next_st = st;                                   // other index
      endcase
    end
  end

  // register the copy; undefined after power-up
  always_ff @(posedge pclk) begin
    st <= next_st;
  end

  assign counts = st;

endmodule : pcr_channel_counts

/* pcr_top.sv */
// register set of a three-channel 16-bit pwm: counts, control, mirrors over apb
// assumes apb3 master on pclk; reload events and output states come from pwm core logic
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps

// What this block does
// - 16-bit phase count per channel, two bytes
// - 16-bit duty count per channel, read/write bytes
// - 16-bit period count per channel, read/write bytes
// - 16-bit offset count per channel, read/write bytes
// - timer value readable and writable as bytes
// - counts undefined at power-up, kept through resets
// - enable mirror bits 2..0 act on channel on-bit
// - reload mirror shares storage with channel arm bit
// - output mirror shows each channel output state
// - mirror bits 7..3 always read zero
// - reload clears arm; software clear cancels arming
// - on-bit enables channel; off forces flags clear
module pcr_top
  import pcr_pkg::*;
#(
  parameter int NCH = PCR_CHANNELS         // channel count
) (
  input wire logic pclk,                   // bus clock, 200 MHz
  input wire logic presetn,                // async reset, active low
  input wire logic psel,                   // apb select
  input wire logic penable,                // apb access phase
  input wire logic pwrite,                 // apb direction
  input wire logic [PCR_ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata,          // apb write data
  input wire logic [NCH-1:0] reload_done,  // pulse: channel finished a reload
  input wire logic [NCH-1:0] out_level,    // channel output state from core
  output logic [31:0] prdata,              // apb read data
  output logic pready,                     // apb ready
  output logic pslverr,                    // apb error, unmapped address
  output logic [NCH-1:0] chan_on,          // channel enables
  output logic [NCH-1:0] reload_arm,       // channel reload arm bits
  output logic [NCH-1:0] flag_clear,       // force interrupt flags clear
  output logic [NCH*80-1:0] count_bus      // all channel counts, packed
);

  // register state other than the counts in one struct
  typedef struct packed {
    logic [NCH-1:0] on;            // module on bits, single storage
    logic [NCH-1:0] arm;           // reload arm bits, single storage
    logic [NCH-1:0] outs;          // sampled output state
    logic [31:0] rdata;            // read data register
    logic ready;                   // ready register
    logic err;                     // error register
    logic [NCH-1:0] flags;         // flag clear levels, own flop
  } pcr_state_s;

  pcr_state_s st;                  // current state
  pcr_state_s next_st;             // next state
  pcr_apb_req_s req;               // bundled request
  pcr_counts_s cnt [NCH];          // counts per channel
  logic [NCH-1:0] cnt_wr;          // count write strobe per channel

  // decode helpers
  logic acc;                       // access phase, first cycle
  logic [1:0] blk;                 // channel block number
  logic [3:0] idx;                 // word index inside block
  logic in_chan;                   // address hits a channel block
  logic chan_ok;                   // block maps to a real channel
  int unsigned ch;                 // selected channel
  logic mapped;                    // address is mapped

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  assign acc = req.sel && req.enable && !st.ready;
  assign blk = req.addr[7:6];
  assign idx = req.addr[5:2];
  assign in_chan = (req.addr[11:8] == 4'h0) && (req.addr[1:0] == 2'h0) && (blk != 2'h0);
  assign ch = 32'(blk - PCR_BLK_CH1);
  assign chan_ok = in_chan && (ch < NCH) && (idx <= PCR_IDX_CTRL);
  assign mapped = chan_ok || req.addr == PCR_ADDR_EN_MIR || req.addr == PCR_ADDR_LD_MIR
                  || req.addr == PCR_ADDR_OUT_MIR;

  // count storage, one instance per channel
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign cnt_wr[g] = acc && req.write && chan_ok && (ch == g) && (idx < PCR_IDX_CTRL);
      pcr_channel_counts u_counts (
        .pclk(pclk),
        .wr_en(cnt_wr[g]),
        .idx(idx),
        .wbyte(req.wdata[7:0]),
        .counts(cnt[g])
      );
      assign count_bus[g*80 +: 80] = cnt[g];
    end
  endgenerate

  // read mux for a channel register
  function automatic logic [7:0] chan_byte(input pcr_counts_s c, input logic [3:0] i,
                                           input logic on, input logic arm,
                                           input logic o);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      PCR_IDX_PH_LO: b = c.start_delay_count[7:0];
      PCR_IDX_PH_HI: b = c.start_delay_count[15:8];
      PCR_IDX_DC_LO: b = c.duty_count[7:0];
      PCR_IDX_DC_HI: b = c.duty_count[15:8];
      PCR_IDX_PR_LO: b = c.period_count[7:0];
      PCR_IDX_PR_HI: b = c.period_count[15:8];
      PCR_IDX_OF_LO: b = c.shift_count[7:0];
      PCR_IDX_OF_HI: b = c.shift_count[15:8];
      PCR_IDX_TM_LO: b = c.timer_value[7:0];
      PCR_IDX_TM_HI: b = c.timer_value[15:8];
      PCR_IDX_CTRL: begin
        b[PCR_CTRL_ON_BIT] = on;
        b[PCR_CTRL_OUT_BIT] = o;
        b[PCR_CTRL_ARM_BIT] = arm;
      end
      default: b = 8'h00;
    endcase
    return b;
  endfunction : chan_byte

  // next-state logic: bus answer, control bits, reload clearing
  always_comb begin
    logic [7:0] rb;
    rb = 8'h00;
    next_st = st;
    next_st.ready = acc;                       // one wait state, then ready
    next_st.err = acc && !mapped;
    next_st.outs = out_level;                  // same-clock input from core
    if (acc && !req.write) begin
      if (chan_ok) begin
        rb = chan_byte(cnt[ch], idx, st.on[ch], st.arm[ch], st.outs[ch]);
      end else if (req.addr == PCR_ADDR_EN_MIR) begin
        rb = {5'h00, st.on};
      end else if (req.addr == PCR_ADDR_LD_MIR) begin
        rb = {5'h00, st.arm};
      end else if (req.addr == PCR_ADDR_OUT_MIR) begin
        rb = {5'h00, st.outs};
      end
      next_st.rdata = {24'h000000, rb};
    end
    // hardware clears the arm bit after a reload
    next_st.arm = st.arm & ~reload_done;
    if (acc && req.write) begin
      if (chan_ok && idx == PCR_IDX_CTRL) begin
        next_st.on[ch] = req.wdata[PCR_CTRL_ON_BIT];
        // a fresh arm set wins over a same-cycle reload clear
        next_st.arm[ch] = req.wdata[PCR_CTRL_ARM_BIT];
      end else if (req.addr == PCR_ADDR_EN_MIR) begin
        next_st.on = req.wdata[PCR_MIR_W-1:0];
      end else if (req.addr == PCR_ADDR_LD_MIR) begin
        next_st.arm = req.wdata[PCR_MIR_W-1:0];
      end
    end
    // flag clear has its own flop so the pin does not sit behind an inverter
    next_st.flags = ~next_st.on;
  end

  // register the state; counts live in the leaf and are not reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.on <= PCR_MIR_RST;
      st.arm <= PCR_MIR_RST;
      st.outs <= PCR_MIR_RST;
      st.rdata <= 32'h00000000;
      st.ready <= 1'b0;
      st.err <= 1'b0;
      st.flags <= ~PCR_MIR_RST;               // all channels off, flags held clear
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.err;
  assign chan_on = st.on;
  assign reload_arm = st.arm;
  assign flag_clear = st.flags;

  // a write to the enable mirror lands in the on bits next edge
  property p_en_mirror;
    @(posedge pclk) disable iff (!presetn)
      acc && req.write && req.addr == PCR_ADDR_EN_MIR |=> chan_on == $past(pwdata[2:0]);
  endproperty
  a_en_mirror: assert property (p_en_mirror) else $error("enable mirror write lost");

  // reload completion clears the arm bit unless software rewrites it
  property p_arm_clear;
    @(posedge pclk) disable iff (!presetn)
      (|reload_done) && !(acc && req.write) |=> (reload_arm & $past(reload_done)) == '0;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("arm not cleared on reload");

  // mirror read of reload arm matches storage, upper bits zero
  property p_ld_read;
    @(posedge pclk) disable iff (!presetn)
      acc && !req.write && req.addr == PCR_ADDR_LD_MIR && !(|reload_done)
      |=> prdata == {29'h0, reload_arm} && pready;
  endproperty
  a_ld_read: assert property (p_ld_read) else $error("reload mirror read wrong");

  // output mirror read shows sampled states
  property p_out_read;
    @(posedge pclk) disable iff (!presetn)
      acc && !req.write && req.addr == PCR_ADDR_OUT_MIR
      |=> prdata[2:0] == $past(st.outs) && prdata[31:3] == 29'h0;
  endproperty
  a_out_read: assert property (p_out_read) else $error("output mirror read wrong");

  // channel control write is seen through the enable mirror
  property p_shared;
    @(posedge pclk) disable iff (!presetn)
      acc && req.write && chan_ok && idx == PCR_IDX_CTRL && ch == 0
      |=> chan_on[0] == $past(pwdata[7]);
  endproperty
  a_shared: assert property (p_shared) else $error("mirror storage not shared");

  // flags forced clear exactly while channel is off
  property p_flags;
    @(posedge pclk) disable iff (!presetn) flag_clear == ~chan_on;
  endproperty
  a_flags: assert property (p_flags) else $error("flag clear mismatch");

  // channel 0 duty low byte write lands in the stored count
  property p_dc_rw;
    @(posedge pclk) disable iff (!presetn)
      acc && req.write && chan_ok && ch == 0 && idx == PCR_IDX_DC_LO
      |=> cnt[0].duty_count[7:0] == $past(pwdata[7:0]);
  endproperty
  a_dc_rw: assert property (p_dc_rw) else $error("duty low byte not stored");

  // ready is one cycle after access start and lasts one cycle
  property p_ready;
    @(posedge pclk) disable iff (!presetn) acc |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready timing wrong");

  // timer high byte write lands in the upper half
  property p_tm_hi;
    @(posedge pclk) disable iff (!presetn)
      acc && req.write && chan_ok && ch == 0 && idx == PCR_IDX_TM_HI
      |=> cnt[0].timer_value[15:8] == $past(pwdata[7:0]);
  endproperty
  a_tm_hi: assert property (p_tm_hi) else $error("timer high byte not stored");

  // unmapped or misaligned access answers with an error beside ready
  property p_unmapped;
    @(posedge pclk) disable iff (!presetn) acc && !mapped |=> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  // a refused read hands back zero, never stale data
  property p_unmapped_rd;
    @(posedge pclk) disable iff (!presetn)
      acc && !req.write && !mapped |=> prdata == 32'h00000000;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

  // error never shows without ready
  property p_err_ready;
    @(posedge pclk) disable iff (!presetn) pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");

  // reload mirror write lands in the arm bits, over a same-cycle reload
  property p_ld_write;
    @(posedge pclk) disable iff (!presetn)
      acc && req.write && req.addr == PCR_ADDR_LD_MIR |=> reload_arm == $past(pwdata[2:0]);
  endproperty
  a_ld_write: assert property (p_ld_write) else $error("reload mirror write lost");

  // enable mirror read shows the on bits, upper bits zero
  property p_en_read;
    @(posedge pclk) disable iff (!presetn)
      acc && !req.write && req.addr == PCR_ADDR_EN_MIR |=> prdata == {29'h0, $past(chan_on)};
  endproperty
  a_en_read: assert property (p_en_read) else $error("enable mirror read wrong");

  // channel 0 control read shows the shared on, arm and output bits
  property p_ctrl_read;
    @(posedge pclk) disable iff (!presetn)
      acc && !req.write && chan_ok && ch == 0 && idx == PCR_IDX_CTRL
      |=> prdata[PCR_CTRL_ON_BIT] == $past(st.on[0])
          && prdata[PCR_CTRL_ARM_BIT] == $past(st.arm[0])
          && prdata[PCR_CTRL_OUT_BIT] == $past(st.outs[0])
          && prdata[31:8] == 24'h000000;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read not shared");

  // on bits move only on a bus write
  property p_on_idle;
    @(posedge pclk) disable iff (!presetn) !(acc && req.write) |=> $stable(chan_on);
  endproperty
  a_on_idle: assert property (p_on_idle) else $error("on bits changed without write");

  // arm bits move only on a bus write or a reload
  property p_arm_idle;
    @(posedge pclk) disable iff (!presetn)
      !(acc && req.write) && !(|reload_done) |=> $stable(reload_arm);
  endproperty
  a_arm_idle: assert property (p_arm_idle) else $error("arm bits changed on their own");

endmodule : pcr_top

/* testbench.sv */
// self-checking bench for the pwm count register set: counts, mirrors, apb refusals
// assumes pcr_top with pcr_pkg map; bench drives every port, no far-side model
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (got), (exp)); end end

module testbench;
  import pcr_pkg::*;
  logic pclk = 1'b0;            // 200 MHz bus clock
  logic presetn = 1'b0;         // async reset, active low
  logic psel = 1'b0;            // apb select
  logic penable = 1'b0;         // apb access phase
  logic pwrite = 1'b0;          // apb direction
  logic [11:0] paddr = '0;      // apb byte address
  logic [31:0] pwdata = '0;     // apb write data
  logic [2:0] reload_done = '0; // reload finished pulses
  logic [2:0] out_level = '0;   // core output states
  logic [31:0] prdata;          // read data
  logic pready;                 // ready
  logic pslverr;                // error
  logic [2:0] chan_on;          // channel enables
  logic [2:0] reload_arm;       // arm bits
  logic [2:0] flag_clear;       // flag clear levels
  logic [239:0] count_bus;      // packed counts
  int n_errors = 0;             // mismatches
  int n_tests = 0;              // comparisons
  logic [7:0] mem [3][10];      // bench copy of count bytes
  logic [31:0] rd;              // last read data
  logic err;                    // last error response
  logic [7:0] v;                // random mirror value
  logic [2:0] ol;               // driven output levels

  // free-running clock
  always #2.5 pclk = ~pclk;

  pcr_top #(.NCH(3)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .reload_done(reload_done),
    .out_level(out_level), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_on(chan_on), .reload_arm(reload_arm), .flag_clear(flag_clear),
    .count_bus(count_bus));

  // byte address of channel c (0..2), word index i
  function automatic logic [11:0] caddr(input int c, input int i);
    return 12'((c + 1) * 64 + i * 4);
  endfunction : caddr

  // expected 16-bit count k (0 phase .. 4 timer) of channel g
  function automatic logic [15:0] exp_field(input int g, input int k);
    return {mem[g][2*k+1], mem[g][2*k]};
  endfunction : exp_field

  // one apb transfer; waits for ready with a bound, no fixed latency assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      $display("[FAIL] t=%0t no ready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // prints counts and verdict, ends the run
  task give_verdict;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // watchdog: the whole run needs under a thousand cycles
  initial begin
    #100000;
    n_errors++;
    $display("[FAIL] t=%0t watchdog", $time);
    give_verdict;
  end

  // main sequence
  initial begin
    void'($urandom(32'h70273fda));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    `CHK(chan_on, 3'h0)
    `CHK(flag_clear, 3'h7)
    for (int m = 0; m < 3; m++) begin
      apb(1'b0, 12'(m * 4), '0);
      `CHK(rd, 32'h0)
    end
    $display("test reset_values done");
    // pass 0 writes 00 to low bytes and FF to high bytes, pass 1 random; upper data bits junk
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 3; c++) for (int i = 0; i < 10; i++) begin
        v = (p == 0) ? ((i % 2) ? 8'hFF : 8'h00) : 8'($urandom);
        mem[c][i] = v;
        apb(1'b1, caddr(c, i), {24'($urandom), v});
      end
      for (int c = 0; c < 3; c++) for (int i = 0; i < 10; i++) begin
        apb(1'b0, caddr(c, i), '0);
        `CHK(rd, {24'h0, mem[c][i]})
        `CHK(err, 1'b0)
      end
      for (int g = 0; g < 3; g++) for (int k = 0; k < 5; k++)
        `CHK(count_bus[g*80+(4-k)*16 +: 16], exp_field(g, k))
    end
    $display("test counts done");
    // enable mirror, upper bits written as ones must read zero
    for (int p = 0; p < 4; p++) begin
      v = (p == 0) ? 8'hFF : 8'($urandom);
      apb(1'b1, PCR_ADDR_EN_MIR, {24'h0, v});
      #1;
      `CHK(chan_on, v[2:0])
      `CHK(flag_clear, ~v[2:0])
      apb(1'b0, PCR_ADDR_EN_MIR, '0);
      `CHK(rd, {29'h0, v[2:0]})
      for (int c = 0; c < 3; c++) begin
        apb(1'b0, caddr(c, 10), '0);
        `CHK(rd[7], v[c])
      end
    end
    apb(1'b1, caddr(1, 10), 32'h80);
    apb(1'b0, PCR_ADDR_EN_MIR, '0);
    `CHK(rd[1], 1'b1)
    $display("test enable_mirror done");
    // reload arm: set all, one hardware clear, one software clear
    apb(1'b1, PCR_ADDR_LD_MIR, 32'hFF);
    #1;
    `CHK(reload_arm, 3'h7)
    apb(1'b0, PCR_ADDR_LD_MIR, '0);
    `CHK(rd, 32'h7)
    reload_done <= 3'b010;
    @(posedge pclk);
    reload_done <= 3'b000;
    @(posedge pclk);
    #1;
    `CHK(reload_arm, 3'b101)
    apb(1'b1, caddr(0, 10), 32'h00);
    apb(1'b0, PCR_ADDR_LD_MIR, '0);
    `CHK(rd, 32'h4)
    `CHK(chan_on[0], 1'b0)
    $display("test reload_arm done");
    // output state mirror follows the core; writes do not stick
    for (int p = 0; p < 4; p++) begin
      ol = 3'($urandom);
      out_level <= ol;
      repeat (2) @(posedge pclk);
      apb(1'b1, PCR_ADDR_OUT_MIR, {24'h0, 5'h1F, ~ol});
      apb(1'b0, PCR_ADDR_OUT_MIR, '0);
      `CHK(rd, {29'h0, ol})
      apb(1'b0, caddr(2, 10), '0);
      `CHK(rd[5], ol[2])
    end
    $display("test output_mirror done");
    // unmapped and misaligned places are refused and read zero
    ol = chan_on;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, (m == 0) ? 12'h00C : (m == 1) ? caddr(0, 11) : (m == 2) ? 12'h002 : 12'h100,
        32'hFF);
      `CHK(err, 1'b1)
      apb(1'b0, (m == 0) ? 12'h00C : (m == 1) ? caddr(0, 11) : (m == 2) ? 12'h002 : 12'h100,
        '0);
      `CHK(rd, 32'h0)
    end
    `CHK(chan_on, ol)
    $display("test unmapped done");
    // reset in mid-run: controls go back, counts survive
    apb(1'b1, PCR_ADDR_EN_MIR, 32'h7);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    `CHK(chan_on, 3'h0)
    `CHK(reload_arm, 3'h0)
    `CHK(flag_clear, 3'h7)
    for (int c = 0; c < 3; c++) for (int i = 0; i < 10; i++) begin
      apb(1'b0, caddr(c, i), '0);
      `CHK(rd, {24'h0, mem[c][i]})
    end
    $display("test reset_keeps_counts done");
    give_verdict;
  end
endmodule : testbench
